/* verilog/sys_ctrl.sv */
`timescale 1ns/100ps
`include "sys_ctrl_regs.svh"
// Functional notes
// - Command trigger bits start an operation and self-clear when it ends.
// - Command bit 7 discards data, reloads registers from stored values, restarts.
// - Command bit 3 flash update, 1 factory restore, 0 bias correction; bits 2, 4, 5 and 6 unused.
// - A sixteen-bit counter of nonvolatile writes is readable by software.
// - Command bits 3, 1 or 0, alone or together, cause one nonvolatile write and count per command.
// - Control bit 11 checks program memory sum; mismatch sets checksum flag.
// - Memory-test trigger clears itself when the checksum finishes.
// - Data ready claims line 1 or 2 first, alarm second, pin register last.
// - Pin register drives lines 3 and 4, and lines 1 and 2 when free.
// - Control bit 2 enables data ready, bit 1 polarity, bit 0 line.
// - Control register resets to 0x0006: data ready on, high, line 1.
// - Data-ready pulse lasts between 100 and 200 microseconds.
// - Control bit 7 set turns sensor compensation off.
// - Pin register low bits: one makes a line output, zero input.
// - Pin register bits 8 to 11 set levels of lines 1 to 4.
// - Reading bit 8 returns line 1 level when it is an input.
// - Control bit 10 runs self test; result goes to self-test flag.
// - Self-test trigger clears itself when the routine finishes.
// - Writing 0xFF to sleep low byte sleeps until a wake event.
// - Chip select falling, reset pin or power cycle ends sleep.
// - Sleep values 0x00 to 0xFE sleep that many half seconds.
// - Reading status returns then clears flags; persisting ones set again.
// - Alarm indicator select picks line 2 when one, line 1 when zero.
module sys_ctrl #(
    parameter int OP_CYCLES = `OP_TIME_US * `CLK_MHZ,
    parameter int DRDY_CYCLES = ((`DRDY_MIN_US + `DRDY_MAX_US) / 2) * `CLK_MHZ,
    parameter int SLEEP_UNIT_CYCLES = `SLEEP_LSB_MS * 1000 * `CLK_MHZ,
    // Identity values are arbitrary
    parameter logic [15:0] PART_CODE = 16'h1234,
    parameter logic [15:0] LOT_CODE_1 = 16'h0001,
    parameter logic [15:0] LOT_CODE_2 = 16'h0002,
    parameter logic [15:0] LOT_CODE_3 = 16'h0003,
    parameter logic [15:0] UNIT_SERIAL = 16'h0001
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Serial port
    input wire sys_ctrl_pkg::spi_pins_t spi_in,
    output logic dout_out,
    // General-purpose lines
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_n_out,
    // Sensor core
    input wire logic sample_tick_in,
    input wire sys_ctrl_pkg::line_cfg_t alarm_cfg_in,
    input wire logic [1:0] alarm_active_in,
    input wire logic overrange_in,
    input wire logic flash_fail_in,
    input wire logic selftest_fail_in,
    input wire logic [15:0] mem_sum_in,
    input wire logic [15:0] factory_sum_in,
    output logic comp_off_out,
    output logic [3:0] cmd_start_out,
    output logic sleep_out
);
    import sys_ctrl_pkg::*;

    function automatic logic drive_level(input logic act, input logic hi);
        return hi ? act : ~act;
    endfunction

    // ==========================================
    // Pin synchronisers and serial framing
    spi_pins_t sync1_reg, sync2_reg, prev_reg;
    logic [3:0] io_sync1_reg, io_sync2_reg;
    logic [3:0] bit_cnt_reg;
    logic [14:0] rx_reg;
    logic [15:0] tx_reg, rd_word_reg, rd_next;
    logic dout_reg;
    spi_word_t frame;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, frame_done, wr, rd;
    logic [6:0] waddr;
    op_state_t op_state_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= 3'h6;
            sync2_reg <= 3'h6;
            prev_reg <= 3'h6;
            io_sync1_reg <= 4'h0;
            io_sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= spi_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            io_sync1_reg <= io_in;
            io_sync2_reg <= io_sync1_reg;
        end
    end

    assign sclk_rise = ~sync2_reg.cs_n & sync2_reg.sclk & ~prev_reg.sclk;
    assign sclk_fall = ~sync2_reg.cs_n & ~sync2_reg.sclk & prev_reg.sclk;
    assign cs_fall = prev_reg.cs_n & ~sync2_reg.cs_n;
    assign cs_rise = ~prev_reg.cs_n & sync2_reg.cs_n;
    assign frame_done = sclk_rise && bit_cnt_reg == 4'hF;
    assign frame = {rx_reg, sync2_reg.din};
    assign wr = frame_done & frame.write & (op_state_reg == OP_IDLE);
    assign rd = frame_done & ~frame.write;
    assign waddr = frame.addr;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_cnt_reg <= 4'h0;
            rx_reg <= 15'h0000;
        end else if (cs_fall) begin
            bit_cnt_reg <= 4'h0;
        end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            rx_reg <= {rx_reg[13:0], sync2_reg.din};
        end
    end

    // Reply goes out in the frame after the read word
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_reg <= 16'h0000;
            dout_reg <= 1'b0;
            rd_word_reg <= 16'h0000;
        end else begin
            if (rd)
                rd_word_reg <= rd_next;
            if (sclk_fall && bit_cnt_reg == 4'h0) begin
                dout_reg <= rd_word_reg[15];
                tx_reg <= {rd_word_reg[14:0], 1'b0};
            end else if (sclk_fall) begin
                dout_reg <= tx_reg[15];
                tx_reg <= {tx_reg[14:0], 1'b0};
            end
        end
    end
    assign dout_out = dout_reg;

    // ==========================================
    // Trigger operations
    logic [31:0] op_cnt_reg;
    logic [7:0] cmd_bits_reg;
    logic [3:0] cmd_start_reg;
    logic [15:0] nvm_count_reg;
    logic op_done, sw_reload, cmd_wr, cksum_wr, selftest_wr;

    assign cmd_wr = wr && waddr == `ADDR_CMD && (frame.data & `CMD_MASK) != 8'h00;
    assign cksum_wr = wr && waddr == (`ADDR_MISC + 7'h01) && frame.data[`MISC_CKSUM - 8];
    assign selftest_wr = wr && waddr == (`ADDR_MISC + 7'h01) && frame.data[`MISC_SELFTEST - 8];
    assign op_done = op_state_reg != OP_IDLE && op_cnt_reg == 32'h0;
    assign sw_reload = op_done && op_state_reg == OP_CMD && cmd_bits_reg[`CMD_SWRESET];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            op_state_reg <= OP_IDLE;
            op_cnt_reg <= 32'h0;
            cmd_bits_reg <= 8'h00;
        end else begin
            unique case (op_state_reg)
                OP_IDLE: begin
                    op_cnt_reg <= 32'(OP_CYCLES - 1);
                    if (cmd_wr) begin
                        op_state_reg <= OP_CMD;
                        cmd_bits_reg <= frame.data & `CMD_MASK;
                    end else if (cksum_wr) begin
                        op_state_reg <= OP_CKSUM;
                    end else if (selftest_wr) begin
                        op_state_reg <= OP_SELFTEST;
                    end
                end
                OP_CMD, OP_SELFTEST, OP_CKSUM: begin
                    if (op_cnt_reg == 32'h0) begin
                        op_state_reg <= OP_IDLE;
                        cmd_bits_reg <= 8'h00;
                    end else begin
                        op_cnt_reg <= op_cnt_reg - 32'h1;
                    end
                end
            endcase
        end
    end

    // Counter survives software reset, as it tracks wear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            nvm_count_reg <= `RST_NVM_COUNT;
            cmd_start_reg <= 4'h0;
        end else begin
            cmd_start_reg <= 4'h0;
            if (cmd_wr && op_state_reg == OP_IDLE &&
                (frame.data & `CMD_NVM_MASK) != 8'h00)
                nvm_count_reg <= nvm_count_reg + 16'h1;
            if (cmd_wr && op_state_reg == OP_IDLE)
                cmd_start_reg <= {frame.data[`CMD_SWRESET], frame.data[`CMD_FLASH],
                    frame.data[`CMD_RESTORE], frame.data[`CMD_BIAS]};
        end
    end
    assign cmd_start_out = cmd_start_reg;

    // ==========================================
    // Control registers
    logic [15:0] misc_reg, pin_io_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            misc_reg <= `RST_MISC;
        end else if (sw_reload) begin
            misc_reg <= `RST_MISC;
        end else if (wr && waddr == `ADDR_MISC) begin
            misc_reg[`MISC_NOCOMP] <= frame.data[`MISC_NOCOMP];
            misc_reg[2:0] <= frame.data[2:0];
        end
    end
    assign comp_off_out = misc_reg[`MISC_NOCOMP];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_io_reg <= `RST_PIN_IO;
        end else if (sw_reload) begin
            pin_io_reg <= `RST_PIN_IO;
        end else if (wr && waddr == `ADDR_PIN_IO) begin
            pin_io_reg[3:0] <= frame.data[3:0];
        end else if (wr && waddr == (`ADDR_PIN_IO + 7'h01)) begin
            pin_io_reg[11:8] <= frame.data[3:0];
        end
    end

    // ==========================================
    // Data ready pulse and line ownership
    logic [31:0] drdy_cnt_reg;
    logic drdy_active, sleeping_reg;
    logic [3:0] io_out_reg, io_oe_n_reg, io_out_next, io_oe_n_next;
    line_cfg_t dr_cfg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            drdy_cnt_reg <= 32'h0;
        else if (sample_tick_in && !sleeping_reg && drdy_cnt_reg == 32'h0)
            drdy_cnt_reg <= 32'(DRDY_CYCLES);
        else if (drdy_cnt_reg != 32'h0)
            drdy_cnt_reg <= drdy_cnt_reg - 32'h1;
    end
    assign drdy_active = drdy_cnt_reg != 32'h0;
    assign dr_cfg = misc_reg[2:0];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_oe_n_next[i] = ~pin_io_reg[i];
            io_out_next[i] = pin_io_reg[`PIN_LEVEL_LSB + i];
        end
        for (int i = 0; i < 2; i++) begin
            if (dr_cfg.enable && dr_cfg.line2 == i[0]) begin
                io_oe_n_next[i] = 1'b0;
                io_out_next[i] = drive_level(drdy_active, dr_cfg.active_high);
            end else if (alarm_cfg_in.enable && alarm_cfg_in.line2 == i[0]) begin
                io_oe_n_next[i] = 1'b0;
                io_out_next[i] = drive_level(|alarm_active_in, alarm_cfg_in.active_high);
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            io_out_reg <= 4'h0;
            io_oe_n_reg <= 4'hF;
        end else begin
            io_out_reg <= io_out_next;
            io_oe_n_reg <= io_oe_n_next;
        end
    end
    assign io_out = io_out_reg;
    assign io_oe_n_out = io_oe_n_reg;

    // ==========================================
    // Sleep
    logic [7:0] sleep_reg, sleep_left_reg;
    logic [31:0] unit_cnt_reg;
    logic forever_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sleep_reg <= `RST_SLEEP;
            sleeping_reg <= 1'b0;
            forever_reg <= 1'b0;
            sleep_left_reg <= 8'h00;
            unit_cnt_reg <= 32'h0;
        end else if (cs_fall && sleeping_reg) begin
            sleeping_reg <= 1'b0;
        end else if (sw_reload) begin
            sleep_reg <= `RST_SLEEP;
        end else if (wr && waddr == `ADDR_SLEEP) begin
            sleep_reg <= frame.data;
            forever_reg <= frame.data == `SLEEP_FOREVER;
            sleeping_reg <= frame.data != 8'h00;
            sleep_left_reg <= frame.data;
            unit_cnt_reg <= 32'(SLEEP_UNIT_CYCLES - 1);
        end else if (sleeping_reg && !forever_reg) begin
            if (unit_cnt_reg != 32'h0) begin
                unit_cnt_reg <= unit_cnt_reg - 32'h1;
            end else begin
                unit_cnt_reg <= 32'(SLEEP_UNIT_CYCLES - 1);
                sleep_left_reg <= sleep_left_reg - 8'h01;
                if (sleep_left_reg == 8'h01)
                    sleeping_reg <= 1'b0;
            end
        end
    end
    assign sleep_out = sleeping_reg;

    // ==========================================
    // Status flags, set wins over read clear
    logic [15:0] diag_reg, diag_set;
    logic diag_clear;

    always_comb begin
        diag_set = 16'h0000;
        if (sample_tick_in) begin
            diag_set[`DIAG_ALARM1 +: 2] = alarm_active_in;
            diag_set[`DIAG_RANGE] = overrange_in;
            diag_set[`DIAG_FLASH] = flash_fail_in;
        end
        if (op_done && op_state_reg == OP_CKSUM)
            diag_set[`DIAG_CKSUM] = mem_sum_in != factory_sum_in;
        if (op_done && op_state_reg == OP_SELFTEST)
            diag_set[`DIAG_SELFTEST] = selftest_fail_in;
        diag_set[`DIAG_SPI] = cs_rise && bit_cnt_reg != 4'h0;
    end
    assign diag_clear = rd && {frame.addr[6:1], 1'b0} == `ADDR_DIAG;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            diag_reg <= 16'h0000;
        else
            diag_reg <= (diag_clear ? 16'h0000 : diag_reg) | diag_set;
    end

    // ==========================================
    // Read mux
    always_comb begin
        rd_next = 16'h0000;
        unique case ({frame.addr[6:1], 1'b0})
            `ADDR_NVM_COUNT: rd_next = nvm_count_reg;
            `ADDR_PIN_IO: begin
                rd_next = pin_io_reg;
                for (int i = 0; i < 4; i++)
                    if (!pin_io_reg[i])
                        rd_next[`PIN_LEVEL_LSB + i] = io_sync2_reg[i];
            end
            `ADDR_MISC: begin
                rd_next = misc_reg;
                rd_next[`MISC_CKSUM] = op_state_reg == OP_CKSUM;
                rd_next[`MISC_SELFTEST] = op_state_reg == OP_SELFTEST;
            end
            `ADDR_SLEEP: rd_next = {8'h00, sleep_reg};
            `ADDR_DIAG: rd_next = diag_reg;
            `ADDR_CMD: rd_next = {8'h00, cmd_bits_reg};
            `ADDR_LOT1: rd_next = LOT_CODE_1;
            `ADDR_LOT2: rd_next = LOT_CODE_2;
            `ADDR_LOT3: rd_next = LOT_CODE_3;
            `ADDR_PART: rd_next = PART_CODE;
            `ADDR_SERIAL: rd_next = UNIT_SERIAL;
            default: rd_next = 16'h0000;
        endcase
    end

    // ==========================================
    // Checks
    logic [31:0] dr_len_reg;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            dr_len_reg <= 32'h0;
        else
            dr_len_reg <= drdy_active ? dr_len_reg + 32'h1 : 32'h0;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_trigger_self_clear: assert property (
        op_done |=> op_state_reg == OP_IDLE && cmd_bits_reg == 8'h00)
        else $error("trigger did not clear");
    chk_soft_reset_reload: assert property (
        sw_reload |=> misc_reg == `RST_MISC && pin_io_reg == `RST_PIN_IO)
        else $error("software reset did not reload");
    chk_cmd_unused_bits: assert property (
        wr && waddr == `ADDR_CMD && (frame.data & `CMD_MASK) == 8'h00
        |=> op_state_reg == OP_IDLE)
        else $error("unused command bit started work");
    chk_nvm_count_step: assert property (
        cmd_wr && frame.data[`CMD_FLASH] |=> nvm_count_reg == $past(nvm_count_reg) + 16'h1)
        else $error("write counter did not step");
    chk_cksum_flag_set: assert property (
        op_done && op_state_reg == OP_CKSUM && mem_sum_in != factory_sum_in
        |=> diag_reg[`DIAG_CKSUM])
        else $error("checksum mismatch not flagged");
    chk_drdy_line_owner: assert property (
        dr_cfg.enable && !dr_cfg.line2 |=> !io_oe_n_out[0] &&
        io_out[0] == drive_level($past(drdy_active), $past(dr_cfg.active_high)))
        else $error("data ready lost its line");
    chk_drdy_pulse_width: assert property (
        $fell(drdy_active) |-> dr_len_reg == 32'(DRDY_CYCLES))
        else $error("data ready width wrong");
    chk_sleep_cs_wake: assert property (
        sleeping_reg && cs_fall |=> !sleeping_reg)
        else $error("sleep not ended by chip select");
    chk_diag_read_clear: assert property (
        diag_clear && diag_set == 16'h0000 |=> diag_reg == 16'h0000)
        else $error("status not cleared on read");
    chk_busy_reads_set: assert property (
        rd && frame.addr == `ADDR_MISC + 7'h01 && op_state_reg == OP_SELFTEST
        |=> rd_word_reg[`MISC_SELFTEST])
        else $error("busy trigger read as clear");

    cov_soft_reset: cover property (sw_reload);
    cov_timed_wake: cover property ($fell(sleeping_reg) && !forever_reg);
    cov_diag_read: cover property (diag_clear && diag_reg != 16'h0000);
endmodule

/* verilog/sys_ctrl_regs.svh */
`ifndef SYS_CTRL_REGS_SVH
`define SYS_CTRL_REGS_SVH
// ==========================================
// Register byte addresses
`define ADDR_NVM_COUNT 7'h00
`define ADDR_PIN_IO 7'h1A
`define ADDR_MISC 7'h1C
`define ADDR_SLEEP 7'h24
`define ADDR_DIAG 7'h26
`define ADDR_CMD 7'h28
`define ADDR_LOT1 7'h32
`define ADDR_LOT2 7'h34
`define ADDR_LOT3 7'h36
`define ADDR_PART 7'h38
`define ADDR_SERIAL 7'h3A
// ==========================================
// Reset values
`define RST_PIN_IO 16'h0000
`define RST_MISC 16'h0006
`define RST_SLEEP 8'h00
`define RST_NVM_COUNT 16'h0000
// ==========================================
// Field positions
`define CMD_SWRESET 7
`define CMD_FLASH 3
`define CMD_RESTORE 1
`define CMD_BIAS 0
`define CMD_MASK 8'h8B
`define CMD_NVM_MASK 8'h0B
`define MISC_CKSUM 11
`define MISC_SELFTEST 10
`define MISC_NOCOMP 7
`define MISC_DR_EN 2
`define MISC_DR_POL 1
`define MISC_DR_SEL 0
`define DIAG_ALARM1 8
`define DIAG_CKSUM 6
`define DIAG_SELFTEST 5
`define DIAG_RANGE 4
`define DIAG_SPI 3
`define DIAG_FLASH 2
`define PIN_LEVEL_LSB 8
`define SLEEP_FOREVER 8'hFF
// ==========================================
// Timing
`define CLK_MHZ 200
`define DRDY_MIN_US 100
`define DRDY_MAX_US 200
`define SLEEP_LSB_MS 500
`define OP_TIME_US 1000
`endif

/* verilog/sys_ctrl_pkg.sv */
package sys_ctrl_pkg;
    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [7:0] data;
    } spi_word_t;
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } spi_pins_t;
    typedef struct packed {
        logic enable;
        logic active_high;
        logic line2;
    } line_cfg_t;
    typedef enum logic [3:0] {
        OP_IDLE = 4'b0001,
        OP_CMD = 4'b0010,
        OP_SELFTEST = 4'b0100,
        OP_CKSUM = 4'b1000
    } op_state_t;
endpackage

/* testbench/spi_host.sv */
`timescale 1ns/100ps
// ==========================================
// Host serial master, mode 3, 48 ns bit period
module spi_host (
    // Pins toward the device
    output sys_ctrl_pkg::spi_pins_t spi_out,
    input wire logic dout_in
);
    import sys_ctrl_pkg::*;
    initial begin
        spi_out = '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
    end
    // callers keep misc bits 9:8 zero
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        spi_out.cs_n = 1'b0;
        #24;
        for (int i = 15; i >= 0; i--) begin
            spi_out.sclk = 1'b0;
            spi_out.din = tx[i];
            #24;
            spi_out.sclk = 1'b1;
            rx[i] = dout_in;
            #24;
        end
        spi_out.cs_n = 1'b1;
        // Released line must not look like held data
        spi_out.din = ~spi_out.din;
        #100;
    endtask
    // Short frame of four clocks to provoke the framing error flag
    task automatic cut();
        spi_out.cs_n = 1'b0;
        #24;
        repeat (4) begin
            spi_out.sclk = 1'b0;
            #24;
            spi_out.sclk = 1'b1;
            #24;
        end
        spi_out.cs_n = 1'b1;
        #100;
    endtask
endmodule

/* testbench/test_sys_ctrl.sv */
`timescale 1ns/100ps
`include "sys_ctrl_regs.svh"
module test_sys_ctrl;
    import sys_ctrl_pkg::*;
    localparam int OPC = 400;
    localparam int DRC = 10;
    localparam int SLU = 20;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    spi_pins_t spi;
    logic dout, tick, ovr, ffail, sfail, comp_off, sleep;
    logic [3:0] pins_in, io_o, io_oe_n, starts;
    logic [15:0] msum, fsum, d;
    logic [1:0] alm_act;
    line_cfg_t alm;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int nstart = 0;
    int n;
    always #2.5 clk_in = ~clk_in;
    spi_host host (.spi_out(spi), .dout_in(dout));
    sys_ctrl #(.OP_CYCLES(OPC), .DRDY_CYCLES(DRC), .SLEEP_UNIT_CYCLES(SLU)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .spi_in(spi), .dout_out(dout),
        .io_in(pins_in), .io_out(io_o), .io_oe_n_out(io_oe_n),
        .sample_tick_in(tick), .alarm_cfg_in(alm), .alarm_active_in(alm_act),
        .overrange_in(ovr), .flash_fail_in(ffail), .selftest_fail_in(sfail),
        .mem_sum_in(msum), .factory_sum_in(fsum), .comp_off_out(comp_off),
        .cmd_start_out(starts), .sleep_out(sleep)
    );
    // ==========================================
    // Shared tasks
    task automatic summarize();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int k);
        repeat (k) @(negedge clk_in);
    endtask
    task automatic wr(input logic [15:0] w);
        logic [15:0] r;
        host.xfer(w, r);
        wt(2);
    endtask
    // Reply arrives in the following frame
    task automatic rd(input logic [6:0] a, output logic [15:0] v);
        host.xfer({1'b0, a, 8'h00}, v);
        host.xfer(16'h0000, v);
        wt(2);
    endtask
    task automatic pulse_tick();
        tick = 1'b1;
        wt(1);
        tick = 1'b0;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (starts != 4'h0)
            nstart++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(`ADDR_MISC, d);
        chk(d, 16'h0006);
        rd(`ADDR_PIN_IO, d);
        chk(d, 16'h0000);
        rd(7'h40, d);
        chk(d, 16'h0000);
        chk({15'h0000, io_oe_n[0]}, 16'h0000);
    endtask
    task automatic t_pins();
        wr(16'h9A02);
        wr(16'h9B02);
        chk({14'h0000, io_oe_n[1], io_o[1]}, 16'h0001);
        wr(16'h9C00);
        pins_in = 4'h1;
        wt(4);
        chk({15'h0000, io_oe_n[0]}, 16'h0001);
        rd(`ADDR_PIN_IO, d);
        chk(d, 16'h0302);
        wr(16'h9A0E);
        wr(16'h9B0E);
        chk({12'h000, io_oe_n[3:2], io_o[3:2]}, 16'h0003);
        wr(16'h9C06);
    endtask
    task automatic t_drdy();
        pulse_tick();
        for (n = 0; n < 5 && io_o[0] !== 1'b1; n++)
            wt(1);
        for (n = 0; n < 100 && io_o[0] === 1'b1; n++)
            wt(1);
        chk(16'(n), 16'(DRC));
        wr(16'h9C04);
        chk({15'h0000, io_o[0]}, 16'h0001);
        wr(16'h9C07);
        chk({14'h0000, io_oe_n[1:0]}, 16'h0001);
        wr(16'h9C86);
        chk({15'h0000, comp_off}, 16'h0001);
        wr(16'h9C06);
        alm = 3'b101;
        alm_act = 2'h1;
        wt(3);
        chk({14'h0000, io_oe_n[1], io_o[1]}, 16'h0000);
        wr(16'h9C05);
        chk({14'h0000, io_oe_n[1], io_o[1]}, 16'h0001);
        alm = 3'b100;
        wt(3);
        chk({14'h0000, io_oe_n[0], io_o[0]}, 16'h0000);
        alm = 3'b000;
        alm_act = 2'h0;
        wr(16'h9C06);
    endtask
    task automatic t_cmd();
        logic [7:0] bits [3] = '{8'h08, 8'h02, 8'h01};
        for (int i = 0; i < 3; i++) begin
            wr({8'hA8, bits[i]});
            wt(OPC + 10);
            rd(`ADDR_CMD, d);
            chk(d, 16'h0000);
            rd(`ADDR_NVM_COUNT, d);
            chk(d, 16'(i + 1));
        end
        wr(16'hA874);
        chk(16'(nstart), 16'h0003);
        wr(16'h9C00);
        wr(16'hA880);
        wt(OPC + 10);
        rd(`ADDR_MISC, d);
        chk(d, 16'h0006);
        rd(`ADDR_NVM_COUNT, d);
        chk(d, 16'h0003);
    endtask
    task automatic t_diag();
        {ovr, ffail} = 2'h3;
        pulse_tick();
        {ovr, ffail} = 2'h0;
        fsum = 16'h1235;
        wr(16'h9D08);
        wt(OPC + 10);
        rd(`ADDR_DIAG, d);
        chk(d, 16'h0054);
        rd(`ADDR_DIAG, d);
        chk(d, 16'h0000);
        host.cut();
        rd(`ADDR_DIAG, d);
        chk(d, 16'h0008);
        rd(`ADDR_MISC, d);
        chk(d, 16'h0006);
        sfail = 1'b1;
        wr(16'h9D04);
        rd(7'h1D, d);
        chk(d, 16'h0406);
        wt(OPC + 10);
        rd(`ADDR_DIAG, d);
        chk(d, 16'h0020);
        rd(`ADDR_MISC, d);
        chk(d, 16'h0006);
    endtask
    task automatic t_sleep();
        wr(16'hA4FF);
        wt(5);
        chk({15'h0000, sleep}, 16'h0001);
        host.xfer(16'h0000, d);
        chk({15'h0000, sleep}, 16'h0000);
        wr(16'hA404);
        wt(20);
        chk({15'h0000, sleep}, 16'h0001);
        wt(4 * SLU);
        chk({15'h0000, sleep}, 16'h0000);
        wr(16'hA4FF);
        chk({15'h0000, sleep}, 16'h0001);
        rst_in = 1'b1;
        wt(2);
        rst_in = 1'b0;
        wt(5);
        chk({15'h0000, sleep}, 16'h0000);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {tick, ovr, ffail, sfail} = 4'h0;
        pins_in = 4'h0;
        msum = 16'h1234;
        fsum = 16'h1234;
        alm = '0;
        alm_act = 2'h0;
        wt(12);
        rst_in = 1'b0;
        wt(5);
        t_reset();
        t_pins();
        t_drdy();
        t_cmd();
        t_diag();
        t_sleep();
        summarize();
    end
endmodule
